// ### rtl/wwd_top.sv
// window watchdog with mode and wake-source logic
// assumes all pins asynchronous; transceiver reports bus dominance
`timescale 1ns/100ps

module wwd_top
   import wwd_pkg::*;
#(
   parameter int unsigned OSC_PERIOD_NS = OSC_PERIOD_NS_DEF,
   parameter int unsigned INT_OSC_PERIOD_NS = INT_OSC_PERIOD_NS_DEF,
   parameter int unsigned RES_CYC = T_RES_CYC,
   parameter int unsigned SLOW_CYC = OSC_SLOW_CYC,
   parameter int unsigned DOM_CYC = T_DOM_CYC,
   parameter int unsigned REARM_CYC = IGN_REARM_CYC,
   parameter int unsigned IGN_CYC = IGN_FILT_CYC
)
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic watchdog_trigger_n,
   input wire logic ignition_wake_input,
   input wire logic mode_select,
   input wire logic txd_in,
   input wire logic lin_dominant,
   input wire logic vcc_undervoltage,
   input wire logic osc_pin_short_gnd,
   input wire logic osc_pin_open,
   output logic nres_n,
   output logic rxd_out,
   output logic txd_out,
   output logic txd_oe,
   output logic txd_weak_pu,
   output logic vcc_en,
   output logic wd_active,
   output wwd_mode_t mode
);
   // ==========================================================
   // derived counts
   // lead, closed and open windows scale from the oscillator period; the reset pulse counts clocks
   localparam int unsigned OSC_TICK = OSC_PERIOD_NS / CLK_PERIOD_NS;
   localparam int unsigned INT_TICK = INT_OSC_PERIOD_NS / CLK_PERIOD_NS;
   localparam int unsigned DIV_CW = $clog2((OSC_TICK > INT_TICK ? OSC_TICK : INT_TICK) + 1);
   localparam logic [DIV_CW-1:0] OSC_LAST = DIV_CW'(OSC_TICK - 1);
   localparam logic [DIV_CW-1:0] INT_LAST = DIV_CW'(INT_TICK - 1);
   localparam int unsigned RCW = $clog2(RES_CYC + 1);
   localparam int unsigned WCW = RCW > WIN_CW ? RCW : WIN_CW;
   localparam logic [WCW-1:0] RES_LAST = WCW'(RES_CYC - 1);
   localparam logic [WCW-1:0] LEAD_LAST = WCW'(LEAD_PER - 1);
   localparam logic [WCW-1:0] CLOSED_LAST = WCW'(CLOSED_PER - 1);
   localparam logic [WCW-1:0] OPEN_LAST = WCW'(OPEN_PER - 1);
   localparam int unsigned PCW = $clog2(SLOW_CYC + 1);
   localparam logic [PCW-1:0] SLOW_C = PCW'(SLOW_CYC);
   localparam int unsigned ACW = $clog2(SEL_WIN_CYC + 1);
   localparam logic [ACW-1:0] SEL_C = ACW'(SEL_WIN_CYC);

   // ==========================================================
   // pin conditioning
   logic trig_evt;
   logic ign_s;
   logic ign_hit;
   logic ign_rearm;
   logic txd_s;
   logic txd_dom_held;
   logic [4:0] sync1_ff;
   logic [4:0] sync2_ff;
   logic en_d_ff;
   logic lin_d_ff;

   // low pulses of 200ns or less never reach hit
   wwd_pin_filter #(.ACTIVE(1'b0), .HOLD(TRIG_MIN_CYC)) u_trig
   (
      .clk(clk),
      .rst_b(rst_b),
      .pin(watchdog_trigger_n),
      .level(),
      .held(),
      .hit(trig_evt)
   );

   wwd_pin_filter #(.ACTIVE(1'b1), .HOLD(IGN_CYC)) u_ign_hi
   (
      .clk(clk),
      .rst_b(rst_b),
      .pin(ignition_wake_input),
      .level(ign_s),
      .held(),
      .hit(ign_hit)
   );

   wwd_pin_filter #(.ACTIVE(1'b0), .HOLD(REARM_CYC)) u_ign_lo
   (
      .clk(clk),
      .rst_b(rst_b),
      .pin(ignition_wake_input),
      .level(),
      .held(),
      .hit(ign_rearm)
   );

   wwd_pin_filter #(.ACTIVE(1'b0), .HOLD(DOM_CYC)) u_txd
   (
      .clk(clk),
      .rst_b(rst_b),
      .pin(txd_in),
      .level(txd_s),
      .held(txd_dom_held),
      .hit()
   );

   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         sync1_ff <= 5'h00;
         sync2_ff <= 5'h00;
         en_d_ff <= 1'b0;
         lin_d_ff <= 1'b0;
      end
      else
      begin
         sync1_ff <= {osc_pin_open, osc_pin_short_gnd, vcc_undervoltage,
                      lin_dominant, mode_select};
         sync2_ff <= sync1_ff;
         en_d_ff <= sync2_ff[0];
         lin_d_ff <= sync2_ff[1];
      end
   end

   wire en_s = sync2_ff[0];
   wire lin_s = sync2_ff[1];
   wire uv_s = sync2_ff[2];
   wire osc_sh_s = sync2_ff[3];
   wire osc_op_s = sync2_ff[4];
   wire en_fall = en_d_ff & ~en_s;
   wire lin_end = lin_d_ff & ~lin_s;

   // ==========================================================
   // state
   wwd_mode_t mode_ff;
   wwd_mode_t nxt_mode;
   wwd_wd_t wd_ff;
   wwd_wd_t nxt_wd;
   logic [WCW-1:0] wd_cnt_ff;
   logic [WCW-1:0] nxt_cnt;
   logic [DIV_CW-1:0] div_ff;
   logic [PCW-1:0] per_ff;
   logic [ACW-1:0] txd_age_ff;
   logic slow_ff;
   logic fb_seen_ff;
   logic ign_armed_ff;
   logic wake_req_ff;
   logic src_local_ff;
   logic nres_n_ff;
   logic rxd_ff;
   logic txd_oe_ff;
   logic vcc_en_ff;

   // ==========================================================
   // decode
   wire quiet = (mode_ff == MD_SILENT) || (mode_ff == MD_SLEEP);
   wire nxt_quiet = (nxt_mode == MD_SILENT) || (nxt_mode == MD_SLEEP);
   // supply is off in sleep, so its undervoltage means nothing there
   wire uv_act = uv_s && (mode_ff != MD_SLEEP);
   wire nres_low = (wd_ff == WD_RESET);
   // fallback on open resistor or on short with slow triggers
   wire fb = osc_op_s | (osc_sh_s & slow_ff);
   wire fb_rst = fb && trig_evt && fb_seen_ff;
   wire [DIV_CW-1:0] div_last = fb ? INT_LAST : OSC_LAST;
   wire osc_tick = (div_ff == div_last);
   wire ign_wake = quiet && ign_hit && ign_armed_ff;
   // a bus short keeps the line dominant; its end is a wake
   wire rem_wake = quiet && lin_end;
   wire wake_evt = ign_wake || rem_wake;
   wire wake_clr = (mode_ff == MD_NORMAL) && en_s;
   // stuck low transmit may only reach sleep after the dominant time
   wire sleep_ok = !txd_s && ((txd_age_ff < SEL_C) || txd_dom_held);
   wire fs_now = (mode_ff == MD_FAILSAFE);

   // ==========================================================
   // mode sequencing
   always_comb
   begin
      nxt_mode = mode_ff;
      case (mode_ff)
         MD_FAILSAFE:
         begin
            if (en_s && !nres_low)
               nxt_mode = MD_NORMAL;
         end
         MD_NORMAL:
         begin
            if (nres_low)
               nxt_mode = MD_FAILSAFE;
            else if (en_fall && txd_s)
               nxt_mode = MD_SILENT;
            else if (en_fall && sleep_ok)
               nxt_mode = MD_SLEEP;
         end
         MD_SILENT, MD_SLEEP:
         begin
            if (wake_evt || en_s)
               nxt_mode = MD_FAILSAFE;
         end
         default:
            nxt_mode = MD_FAILSAFE;
      endcase
      if (uv_act)
         nxt_mode = MD_FAILSAFE;
   end

   // ==========================================================
   // watchdog sequence
   always_comb
   begin
      nxt_wd = wd_ff;
      nxt_cnt = wd_cnt_ff;
      case (wd_ff)
         WD_OFF:
         begin
            // lead restarts on a wake or select out of silent or sleep; undervoltage out of silent gives reset
            if (!nxt_quiet)
            begin
               nxt_wd = WD_LEAD;
               nxt_cnt = '0;
            end
         end
         WD_RESET:
         begin
            if (wd_cnt_ff == RES_LAST)
            begin
               nxt_wd = WD_LEAD;
               nxt_cnt = '0;
            end
            else
               nxt_cnt = wd_cnt_ff + 1'b1;
         end
         WD_LEAD:
         begin
            if (trig_evt)
            begin
               nxt_wd = WD_CLOSED;
               nxt_cnt = '0;
            end
            else if (osc_tick && wd_cnt_ff == LEAD_LAST)
            begin
               nxt_wd = WD_RESET;
               nxt_cnt = '0;
            end
            else if (osc_tick)
               nxt_cnt = wd_cnt_ff + 1'b1;
         end
         WD_CLOSED:
         begin
            if (trig_evt)
            begin
               nxt_wd = WD_RESET;
               nxt_cnt = '0;
            end
            else if (osc_tick && wd_cnt_ff == CLOSED_LAST)
            begin
               nxt_wd = WD_OPEN;
               nxt_cnt = '0;
            end
            else if (osc_tick)
               nxt_cnt = wd_cnt_ff + 1'b1;
         end
         WD_OPEN:
         begin
            if (trig_evt)
            begin
               nxt_wd = WD_CLOSED;
               nxt_cnt = '0;
            end
            else if (osc_tick && wd_cnt_ff == OPEN_LAST)
            begin
               nxt_wd = WD_RESET;
               nxt_cnt = '0;
            end
            else if (osc_tick)
               nxt_cnt = wd_cnt_ff + 1'b1;
         end
         default:
         begin
            nxt_wd = WD_RESET;
            nxt_cnt = '0;
         end
      endcase
      if (uv_act || fb_rst)
      begin
         nxt_wd = WD_RESET;
         nxt_cnt = '0;
      end
      if (nxt_quiet)
      begin
         nxt_wd = WD_OFF;
         nxt_cnt = '0;
      end
   end

   // ==========================================================
   // registers
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         mode_ff <= MD_FAILSAFE;
         wd_ff <= WD_RESET;
         wd_cnt_ff <= '0;
         div_ff <= '0;
         per_ff <= '0;
         txd_age_ff <= '0;
         slow_ff <= 1'b0;
         fb_seen_ff <= 1'b0;
         ign_armed_ff <= 1'b1;
         wake_req_ff <= 1'b0;
         src_local_ff <= 1'b0;
      end
      else
      begin
         mode_ff <= nxt_mode;
         wd_ff <= nxt_wd;
         wd_cnt_ff <= nxt_cnt;
         div_ff <= osc_tick ? '0 : div_ff + 1'b1;
         per_ff <= trig_evt ? '0 : (per_ff == SLOW_C) ? per_ff : per_ff + 1'b1;
         txd_age_ff <= txd_s ? '0 : (txd_age_ff == SEL_C) ? txd_age_ff : txd_age_ff + 1'b1;
         // slow trigger period only matters while the resistor is shorted
         if (!osc_sh_s)
            slow_ff <= 1'b0;
         else if (trig_evt)
            slow_ff <= (per_ff == SLOW_C);
         fb_seen_ff <= fb && !fb_rst && (fb_seen_ff || trig_evt);
         if (ign_rearm)
            ign_armed_ff <= 1'b1;
         else if (nxt_quiet && !quiet && ign_s)
            ign_armed_ff <= 1'b0;
         // a wake in the clearing cycle is kept
         wake_req_ff <= wake_evt || (wake_req_ff && !wake_clr);
         if (ign_wake)
            src_local_ff <= 1'b1;
         else if (rem_wake || wake_clr)
            src_local_ff <= 1'b0;
      end
   end

   // ==========================================================
   // pin drivers
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         nres_n_ff <= 1'b0;
         rxd_ff <= 1'b1;
         txd_oe_ff <= 1'b0;
         vcc_en_ff <= 1'b1;
      end
      else
      begin
         nres_n_ff <= !nres_low && (mode_ff != MD_SLEEP);
         case (mode_ff)
            MD_NORMAL: rxd_ff <= !lin_s;
            MD_SILENT: rxd_ff <= 1'b1;
            MD_SLEEP: rxd_ff <= 1'b0;
            default: rxd_ff <= !wake_req_ff;
         endcase
         txd_oe_ff <= fs_now && src_local_ff;
         vcc_en_ff <= (nxt_mode != MD_SLEEP);
      end
   end

   assign nres_n = nres_n_ff;
   assign rxd_out = rxd_ff;
   // open-drain style: only ever pulls low
   assign txd_out = 1'b0;
   assign txd_oe = txd_oe_ff;
   assign txd_weak_pu = !txd_oe_ff;
   assign vcc_en = vcc_en_ff;
   assign wd_active = (wd_ff != WD_OFF);
   assign mode = mode_ff;

   // ==========================================================
   // checks
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);

   AST_CLOSED_TRIG:
      assert property ((wd_ff == WD_CLOSED) && trig_evt && !en_fall |=> wd_ff == WD_RESET)
      else $error("trigger in closed window gave no reset");
   AST_OPEN_TRIG:
      assert property ((wd_ff == WD_OPEN) && trig_evt && !fb_rst && !uv_act && !en_fall
                       |=> wd_ff == WD_CLOSED)
      else $error("trigger in open window did not restart");
   AST_RES_END:
      assert property ((wd_ff == WD_RESET) && (wd_cnt_ff == RES_LAST) && !uv_act && !fb_rst
                       |=> wd_ff == WD_LEAD)
      else $error("reset pulse did not end in lead time");
   AST_LEAD_TO:
      assert property ((wd_ff == WD_LEAD) && osc_tick && (wd_cnt_ff == LEAD_LAST) && !trig_evt
                       && !en_fall |=> wd_ff == WD_RESET ##1 !nres_n)
      else $error("lead timeout gave no reset");
   AST_FS_ON_RST:
      assert property (wd_ff == WD_RESET |=> mode_ff == MD_FAILSAFE)
      else $error("reset without fail-safe mode");
   AST_WAKE_CLR:
      assert property (wake_clr |=> !wake_req_ff && !src_local_ff)
      else $error("wake flags not cleared in normal mode");
   AST_LOCAL_TXD:
      assert property (fs_now && src_local_ff |=> txd_oe && !txd_out && !txd_weak_pu)
      else $error("local wake source not shown on transmit pin");
   AST_QUIET_WD:
      assert property (quiet |-> wd_ff == WD_OFF && !wd_active)
      else $error("watchdog running in silent or sleep");
   AST_UV:
      assert property (uv_act |-> ##2 !nres_n && vcc_en && mode_ff == MD_FAILSAFE)
      else $error("undervoltage did not force reset and supply");
   AST_IGN_ARM:
      assert property (quiet && ign_hit && !ign_armed_ff && !rem_wake && !en_s && !uv_act
                       |=> mode_ff == $past(mode_ff))
      else $error("ignition wake accepted without rearm");

   COV_OPEN: cover property (wd_ff == WD_CLOSED ##1 wd_ff == WD_OPEN);
   COV_LOCAL: cover property (ign_wake ##1 fs_now);
   COV_REMOTE: cover property (rem_wake);
   COV_FB_RST: cover property (fb_rst);

endmodule : wwd_top

// ### rtl/wwd_pkg.sv
// window watchdog and wake handling: shared constants and state types
// assumes a single 25 MHz clock and pins already level-shifted to logic
//
// Notes on behaviour
// - ignition high past filter: local wake, fail-safe
// - local wake: receive low, transmit strong pull-down
// - quiet entry with ignition high needs low rearm
// - fail-safe transmit pin: high remote, low local
// - select high in normal clears both wake flags
// - last wake source kept, shown in fail-safe
// - quiet entry allowed with bus short; end wakes
// - supply undervoltage: reset low, fail-safe, supply on
// - stuck transmit low: sleep only after 20ms
// - resistor shorted, slow triggers: internal oscillator fallback
// - resistor open: internal oscillator, reset by second trigger
// - trigger is falling edge held over 200ns
// - missing trigger resets; sequence restarts with lead
// - watchdog off in silent and sleep
// - lead starts at reset release or wake
// - lead 7895, closed 1053, open 1105 periods
// - power-up reset time, trigger in lead starts closed
// - no trigger in lead: 4ms reset pulse
// - open window trigger restarts; timeout resets
// - trigger in closed window resets at once
// - reset low forces fail-safe mode
// - fail-safe until select high, then normal

package wwd_pkg;

   // ==========================================================
   // clock and pin timing
   localparam int unsigned CLK_PERIOD_NS = 40;
   localparam int unsigned TRIG_MIN_NS = 200;
   // strictly longer than the minimum, so one extra sample
   localparam int unsigned TRIG_MIN_CYC = TRIG_MIN_NS / CLK_PERIOD_NS + 1;
   localparam int unsigned IGN_REARM_US = 250;
   localparam int unsigned IGN_REARM_CYC = IGN_REARM_US * 1000 / CLK_PERIOD_NS + 1;
   localparam int unsigned IGN_FILT_US = 150;
   localparam int unsigned IGN_FILT_CYC = IGN_FILT_US * 1000 / CLK_PERIOD_NS + 1;
   localparam int unsigned T_DOM_MS = 20;
   localparam int unsigned T_DOM_CYC = T_DOM_MS * 1000000 / CLK_PERIOD_NS + 1;
   localparam int unsigned SEL_WIN_NS = 10000;
   localparam int unsigned SEL_WIN_CYC = SEL_WIN_NS / CLK_PERIOD_NS;

   // ==========================================================
   // watchdog timing
   localparam int unsigned T_RES_MS = 4;
   localparam int unsigned T_RES_CYC = T_RES_MS * 1000000 / CLK_PERIOD_NS;
   localparam int unsigned OSC_SLOW_MS = 27;
   localparam int unsigned OSC_SLOW_CYC = OSC_SLOW_MS * 1000000 / CLK_PERIOD_NS + 1;
   localparam int unsigned OSC_PERIOD_NS_DEF = 19600;
   localparam int unsigned INT_OSC_PERIOD_NS_DEF = 19600;
   localparam int unsigned LEAD_PER = 7895;
   localparam int unsigned CLOSED_PER = 1053;
   localparam int unsigned OPEN_PER = 1105;
   localparam int unsigned WIN_CW = 13;

   // ==========================================================
   // states
   typedef enum logic [1:0] {MD_FAILSAFE, MD_NORMAL, MD_SILENT, MD_SLEEP} wwd_mode_t;
   typedef enum logic [2:0] {WD_OFF, WD_RESET, WD_LEAD, WD_CLOSED, WD_OPEN} wwd_wd_t;

endpackage : wwd_pkg

// ### rtl/wwd_pin_filter.sv
// pin synchroniser with a hold qualifier
// assumes pin is asynchronous to clk; hit fires once per held level
`timescale 1ns/100ps

module wwd_pin_filter
#(
   parameter logic ACTIVE = 1'b1,
   parameter int unsigned HOLD = 1
)
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic pin,
   output logic level,
   output logic held,
   output logic hit
);
   localparam int unsigned CW = $clog2(HOLD + 1);
   localparam logic [CW-1:0] HOLD_C = CW'(HOLD);
   localparam logic [CW-1:0] HOLD_M1 = CW'(HOLD - 1);

   logic sync1_ff;
   logic sync2_ff;
   logic [CW-1:0] cnt_ff;
   logic hit_ff;
   logic [CW-1:0] nxt_cnt;
   wire is_act = (sync2_ff == ACTIVE);

   assign nxt_cnt = !is_act ? '0 : (cnt_ff == HOLD_C) ? cnt_ff : cnt_ff + 1'b1;

   // reset to the idle level so no false qualify after reset
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         sync1_ff <= ~ACTIVE;
         sync2_ff <= ~ACTIVE;
         cnt_ff <= '0;
         hit_ff <= 1'b0;
      end
      else
      begin
         sync1_ff <= pin;
         sync2_ff <= sync1_ff;
         cnt_ff <= nxt_cnt;
         hit_ff <= is_act && (cnt_ff == HOLD_M1);
      end
   end

   assign level = sync2_ff;
   assign held = (cnt_ff == HOLD_C);
   assign hit = hit_ff;

endmodule : wwd_pin_filter

// ### testbench/wwd_host_model.sv
// host side of the trigger, select and transmit pins
// assumes the bench calls its tasks between rising clock edges
`timescale 1ns/100ps

module wwd_host_model
(
   input wire logic clk,
   output logic trig_n,
   output logic en,
   output logic txd
);
   // ==========================================================
   // idle levels: trigger released, select low, transmit recessive
   initial
   begin
      trig_n = 1'b1;
      en = 1'b0;
      txd = 1'b1;
   end

   // ==========================================================
   // pin tasks
   // a valid trigger stays low well past 200ns; short lengths model glitches
   task pulse(input int len);
      @(negedge clk);
      trig_n <= 1'b0;
      repeat (len) @(negedge clk);
      trig_n <= 1'b1;
   endtask : pulse

   // select and transmit move on the same edge, as a real host does for sleep entry
   task set_pins(input logic e, input logic t);
      @(negedge clk);
      en <= e;
      txd <= t;
   endtask : set_pins
endmodule : wwd_host_model

// ### testbench/test_window_watchdog_wake_logic.sv
// self-checking bench for the window watchdog and wake logic
// assumes a 40ns osc period, so one watchdog tick is one clock
`timescale 1ns/100ps

module test_window_watchdog_wake_logic
   import wwd_pkg::*;
();
   localparam int unsigned RES = 50;
   localparam int unsigned OSC_NS = 40;
   localparam int unsigned TICK = OSC_NS / CLK_PERIOD_NS;
   logic clk, rst_b, ign, lin_dom, uv, osc_open, osc_short, trig_n, en, txd;
   logic nres_n, rxd_out, txd_out, txd_oe, txd_weak_pu, vcc_en, wd_active;
   wwd_mode_t mode;
   int fail_count, num_checks, cycles, n, i;
   logic [31:0] rnd;

   wwd_top #(.OSC_PERIOD_NS(OSC_NS), .INT_OSC_PERIOD_NS(OSC_NS), .RES_CYC(RES),
      .SLOW_CYC(200), .DOM_CYC(500), .REARM_CYC(20), .IGN_CYC(10)) wwd_top_i (
      .clk(clk), .rst_b(rst_b), .watchdog_trigger_n(trig_n), .ignition_wake_input(ign),
      .mode_select(en), .txd_in(txd), .lin_dominant(lin_dom), .vcc_undervoltage(uv),
      .osc_pin_short_gnd(osc_short), .osc_pin_open(osc_open), .nres_n(nres_n),
      .rxd_out(rxd_out), .txd_out(txd_out), .txd_oe(txd_oe), .txd_weak_pu(txd_weak_pu),
      .vcc_en(vcc_en), .wd_active(wd_active), .mode(mode));
   wwd_host_model wwd_host_model_i (.clk(clk), .trig_n(trig_n), .en(en), .txd(txd));

   // ==========================================================
   // helpers
   function logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction : lfsr

   function logic inr(input int v, input int lo, input int hi);
      return (v >= lo && v <= hi);
   endfunction : inr

   task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task chk_mode(input wwd_mode_t exp);
      check("mode", {30'h0, mode}, {30'h0, exp});
   endtask : chk_mode

   task cyc(input int k);
      repeat (k) @(negedge clk);
   endtask : cyc

   // bounded wait for the reset output to reach a level
   task wait_lvl(input logic v, input int maxc, output int cnt);
      cnt = 0;
      while (nres_n !== v && cnt < maxc)
      begin
         @(negedge clk);
         cnt++;
      end
   endtask : wait_lvl

   task report_and_stop;
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : report_and_stop

   // ==========================================================
   // clock and hang guard
   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 40000)
      begin
         fail_count++;
         report_and_stop;
      end
   end

   // ==========================================================
   // main sequence
   initial
   begin
      rst_b = 1'b0;
      ign = 1'b0;
      lin_dom = 1'b0;
      uv = 1'b0;
      osc_open = 1'b0;
      osc_short = 1'b0;
      rnd = 32'h20;
      cyc(12);
      check("reset held", nres_n, 1'b0);
      chk_mode(MD_FAILSAFE);
      rst_b = 1'b1;
      wait_lvl(1'b1, RES + 20, n);
      check("power-up reset time", inr(n, RES, RES + 5), 1'b1);
      $display("test power-up done");

      for (i = 0; i < 3; i++)
      begin
         rnd = lfsr(rnd);
         wwd_host_model_i.pulse(1 + rnd % 4);
         cyc(20);
      end
      wwd_host_model_i.pulse(10);
      // spacing stays inside the open window, as a host within 15 percent would
      for (i = 0; i < 5; i++)
      begin
         rnd = lfsr(rnd);
         cyc(CLOSED_PER * TICK + 89 + rnd % 800);
         wwd_host_model_i.pulse(10);
         check("no reset in open window", nres_n, 1'b1);
      end
      wait_lvl(1'b0, 3000, n);
      check("open window timeout", inr(n + 11, (CLOSED_PER + OPEN_PER) * TICK,
         (CLOSED_PER + OPEN_PER) * TICK + 25), 1'b1);
      wait_lvl(1'b1, 200, n);
      check("reset pulse length", inr(n, RES - 2, RES + 2), 1'b1);
      $display("test window sequence done");

      wwd_host_model_i.pulse(10);
      cyc(300);
      wwd_host_model_i.pulse(10);
      wait_lvl(1'b0, 30, n);
      check("closed window trigger", nres_n, 1'b0);
      wait_lvl(1'b1, 200, n);
      wait_lvl(1'b0, 9000, n);
      check("lead time", inr(n, LEAD_PER * TICK - 6, LEAD_PER * TICK + 6), 1'b1);
      wait_lvl(1'b1, 200, n);
      $display("test closed window done");

      wwd_host_model_i.set_pins(1'b1, 1'b1);
      cyc(10);
      chk_mode(MD_NORMAL);
      wwd_host_model_i.set_pins(1'b0, 1'b1);
      cyc(10);
      chk_mode(MD_SILENT);
      check("watchdog off", wd_active, 1'b0);
      ign = 1'b1;
      cyc(30);
      chk_mode(MD_FAILSAFE);
      check("wake request", rxd_out, 1'b0);
      check("local source", txd_oe, 1'b1);
      check("local source level", txd_out, 1'b0);
      ign = 1'b0;
      wwd_host_model_i.set_pins(1'b1, 1'b1);
      cyc(10);
      chk_mode(MD_NORMAL);
      check("flags cleared rxd", rxd_out, 1'b1);
      check("flags cleared txd", txd_oe, 1'b0);
      lin_dom = 1'b1;
      wwd_host_model_i.set_pins(1'b0, 1'b1);
      cyc(10);
      chk_mode(MD_SILENT);
      lin_dom = 1'b0;
      cyc(10);
      chk_mode(MD_FAILSAFE);
      check("remote wake request", rxd_out, 1'b0);
      check("remote source", txd_weak_pu, 1'b1);
      $display("test wake sources done");

      wwd_host_model_i.set_pins(1'b1, 1'b1);
      cyc(10);
      ign = 1'b1;
      wwd_host_model_i.set_pins(1'b0, 1'b1);
      cyc(40);
      chk_mode(MD_SILENT);
      ign = 1'b0;
      cyc(5);
      ign = 1'b1;
      cyc(40);
      chk_mode(MD_SILENT);
      ign = 1'b0;
      cyc(40);
      ign = 1'b1;
      cyc(40);
      chk_mode(MD_FAILSAFE);
      ign = 1'b0;
      $display("test ignition rearm done");

      wwd_host_model_i.set_pins(1'b1, 1'b0);
      cyc(300);
      wwd_host_model_i.set_pins(1'b0, 1'b0);
      cyc(10);
      chk_mode(MD_NORMAL);
      wwd_host_model_i.set_pins(1'b1, 1'b0);
      cyc(250);
      wwd_host_model_i.set_pins(1'b0, 1'b0);
      cyc(10);
      chk_mode(MD_SLEEP);
      check("supply off in sleep", vcc_en, 1'b0);
      wwd_host_model_i.set_pins(1'b1, 1'b1);
      cyc(20);
      check("supply back on", vcc_en, 1'b1);
      $display("test stuck transmit done");

      cyc(20);
      uv = 1'b1;
      cyc(10);
      check("undervoltage reset", nres_n, 1'b0);
      chk_mode(MD_FAILSAFE);
      check("supply kept on", vcc_en, 1'b1);
      check("no stale wake request", rxd_out, 1'b1);
      check("no stale local source", txd_oe, 1'b0);
      check("watchdog on in fail-safe", wd_active, 1'b1);
      uv = 1'b0;
      $display("test undervoltage done");

      osc_open = 1'b1;
      wait_lvl(1'b1, 300, n);
      wwd_host_model_i.pulse(10);
      cyc(1500);
      wwd_host_model_i.pulse(10);
      wait_lvl(1'b0, 30, n);
      check("fallback reset", nres_n, 1'b0);
      // shorted resistor: fallback needs one slow period, then resets on the second trigger after it
      osc_open = 1'b0;
      osc_short = 1'b1;
      wait_lvl(1'b1, 300, n);
      check("short lead", nres_n, 1'b1);
      cyc(250);
      wwd_host_model_i.pulse(10);
      cyc(1500);
      wwd_host_model_i.pulse(10);
      check("short first slow trigger", nres_n, 1'b1);
      cyc(1500);
      wwd_host_model_i.pulse(10);
      wait_lvl(1'b0, 30, n);
      check("short fallback reset", nres_n, 1'b0);
      $display("test oscillator fallback done");
      report_and_stop;
   end
endmodule : test_window_watchdog_wake_logic
